// ### design/vc_ctl_defs.svh
`ifndef VC_CTL_DEFS_SVH
`define VC_CTL_DEFS_SVH

// Register byte addresses
`define OFS_CONTROL     12'h214
`define OFS_STATUS      12'h218
`define OFS_IRQ_STATUS  12'h300
`define OFS_IRQ_ENABLE  12'h304
`define OFS_IRQ_CLEAR   12'h308

// Control register fields
`define MAP_MSB         7
`define MAP_RW_LSB      1
`define LOAD_BIT        16
`define SEL_LSB         17
`define SEL_MSB         19
`define CHID_LSB        24
`define CHID_MSB        26
`define ENABLE_BIT      31
`define CTL_RSV_MASK    32'h78F1FF00

// Status register fields
`define PEND_BIT        16
`define NEG_BIT         17
`define STS_RSV_MASK    32'hFFFCFFFF

// Reset values and fixed constants
`define MAP_RESET       8'hFF
`define SEL_RESET       3'h0
`define CHID_VALUE      3'h0
`define CAP_UPSTREAM    8'h03
`define CAP_DOWNSTREAM  8'h01

// Interrupt event bits
`define EV_LOAD_DONE    0
`define EV_TABLE_WRITE  1
`define EV_NEG_DONE     2
`define EV_COUNT        3

`endif

// ### design/vc_ctl_pkg.sv
package vc_ctl_pkg;
   // Load sequencing states, one-hot
   typedef enum logic [2:0] {
      LD_IDLE = 3'h1,   // Nothing in flight
      LD_BUSY = 3'h2,   // Waiting for arbiter to latch table
      LD_DONE = 3'h4    // Finishing, clears pending
   } load_state_e;
endpackage : vc_ctl_pkg

// ### design/vc_resource_control_status.sv
`include "vc_ctl_defs.svh"

////////////////////////////////////////////////////////////////////////////
module vc_resource_control_status #(
   parameter bit UPSTREAM = 1'b1     // Port flavour
) (
   input  wire logic        pclk,             // Core clock
   input  wire logic        presetn,          // Async reset, low
   input  wire logic        psel,             // APB select
   input  wire logic        penable,          // APB access phase
   input  wire logic        pwrite,           // APB direction
   input  wire logic [11:0] paddr,            // APB byte address
   input  wire logic [31:0] pwdata,           // APB write data
   output logic      [31:0] prdata,           // APB read data
   output logic             pready,           // APB ready
   output logic             pslverr,          // APB error
   input  wire logic        table_write,      // Table entry written
   input  wire logic        load_done,        // Arbiter latched table
   input  wire logic        link_active,      // Link in DL_Active
   input  wire logic        fc_init2,         // Link in FC_INIT2
   output logic      [7:0]  class_to_channel_map,       // Class map
   output logic      [2:0]  arbitration_scheme_select,  // Scheme
   output logic             load_table_request,         // Load pulse
   output logic             irq                         // Interrupt
);

   ////////////////////////////////////////////////////////////////////////
   // Decoding

   // One decode per register, used by read and write paths
   function automatic logic hit(input logic [11:0] a,
                                input logic [11:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   wire logic        wr_en  = psel & penable & pwrite & pready;
   wire logic        rd_en  = psel & ~penable & ~pwrite;
   wire logic        st_en  = psel & ~penable;
   wire logic        hit_ctl = hit(paddr, `OFS_CONTROL);
   wire logic        hit_sts = hit(paddr, `OFS_STATUS);
   wire logic        hit_ist = hit(paddr, `OFS_IRQ_STATUS);
   wire logic        hit_ien = hit(paddr, `OFS_IRQ_ENABLE);
   wire logic        hit_icl = hit(paddr, `OFS_IRQ_CLEAR);
   wire logic        mapped  = hit_ctl | hit_sts | hit_ist | hit_ien
                               | hit_icl;
   wire logic [7:0]  cap_bits = UPSTREAM ? `CAP_UPSTREAM
                                         : `CAP_DOWNSTREAM;

   ////////////////////////////////////////////////////////////////////////
   // State

   logic [7:0]  map_q;        // Class map
   logic [2:0]  sel_q;        // Scheme select
   logic        pend_q;       // Table pending
   logic        neg_q;        // Negotiation pending
   logic        init2_q;      // Previous FC_INIT2 level
   logic [`EV_COUNT-1:0] ist_q;   // Sticky events
   logic [`EV_COUNT-1:0] ien_q;   // Event enables
   logic        req_q;        // Load request pulse
   logic [31:0] rdata_q;      // Read data
   logic        ready_q;      // Ready flop
   logic        err_q;        // Error flop
   logic        irq_q;        // Interrupt flop
   vc_ctl_pkg::load_state_e st_q;   // Load sequencer
   vc_ctl_pkg::load_state_e st_d;

   // Scheme uses the table only if its capability bit is set and
   // it is not plain round robin; load gating also needs upstream
   wire logic sel_uses_tbl = cap_bits[sel_q] & (sel_q != `SEL_RESET);
   wire logic load_go = wr_en & hit_ctl & pwdata[`LOAD_BIT]
                        & UPSTREAM
                        & sel_uses_tbl
                        & (st_q == vc_ctl_pkg::LD_IDLE);
   wire logic ld_fin  = (st_q == vc_ctl_pkg::LD_DONE);
   wire logic neg_fall = init2_q & ~fc_init2;
   wire logic [`EV_COUNT-1:0] ev;

   assign ev[`EV_LOAD_DONE]  = ld_fin;
   assign ev[`EV_TABLE_WRITE] = table_write & UPSTREAM;
   assign ev[`EV_NEG_DONE]   = neg_fall & link_active;

   ////////////////////////////////////////////////////////////////////////
   // Control register
   // Bit 0 stays one so class zero is always carried
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         map_q <= `MAP_RESET;
         sel_q <= `SEL_RESET;
      end else if (wr_en && hit_ctl) begin
         // Software write; class zero is forced back on
         map_q <= {pwdata[`MAP_MSB:`MAP_RW_LSB], 1'b1};
         sel_q <= pwdata[`SEL_MSB:`SEL_LSB];
      end
   end

   // Class zero can never be dropped from the channel
   chk_map_reset: assert property (
      @(posedge pclk) disable iff (!presetn)
      class_to_channel_map[0])
      else $error("class zero unmapped");

   // Upper seven map bits follow the write data
   chk_map_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_en && hit_ctl) |=> class_to_channel_map ==
      {$past(pwdata[`MAP_MSB:`MAP_RW_LSB]), 1'b1})
      else $error("class map not written");

   // Scheme select takes the written field whole
   chk_sel_write: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_en && hit_ctl) |=> arbitration_scheme_select ==
      $past(pwdata[`SEL_MSB:`SEL_LSB]))
      else $error("scheme select not written");

   ////////////////////////////////////////////////////////////////////////
   // Load sequencer: waits for the arbiter to latch the table
   always_comb begin
      st_d = st_q;
      case (st_q)
         vc_ctl_pkg::LD_IDLE: begin
            if (load_go) st_d = vc_ctl_pkg::LD_BUSY;
         end
         vc_ctl_pkg::LD_BUSY: begin
            if (load_done) st_d = vc_ctl_pkg::LD_DONE;
         end
         vc_ctl_pkg::LD_DONE: begin
            st_d = vc_ctl_pkg::LD_IDLE;
         end
         default: begin
            st_d = vc_ctl_pkg::LD_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q  <= vc_ctl_pkg::LD_IDLE;
         req_q <= 1'b0;
      end else begin
         st_q  <= st_d;
         req_q <= load_go;
      end
   end

   // Request is a single-cycle strobe to the arbiter
   sequence s_req_pulse;
      load_table_request ##1 !load_table_request;
   endsequence

   // Finishing walk: one cycle in LD_DONE, then back to idle
   sequence s_finish;
      (st_q == vc_ctl_pkg::LD_DONE) ##1 (st_q == vc_ctl_pkg::LD_IDLE);
   endsequence

   // Sequencer state stays one-hot
   chk_state_onehot: assert property (
      @(posedge pclk) disable iff (!presetn)
      $onehot(st_q))
      else $error("load state not one-hot");

   // Accepted load raises the strobe for exactly one cycle
   chk_load_pulse: assert property (
      @(posedge pclk) disable iff (!presetn)
      load_go |=> s_req_pulse)
      else $error("load pulse wrong");

   // Downstream flavour never strobes the arbiter
   chk_no_down_load: assert property (
      @(posedge pclk) disable iff (!presetn)
      !UPSTREAM |-> !load_table_request)
      else $error("downstream load");

   // Writing zero to the load bit is a no-op
   chk_zero_no_load: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_en && hit_ctl && !pwdata[`LOAD_BIT]) |=> !load_table_request)
      else $error("zero write loaded");

   // No load while the selected scheme leaves the table unused
   chk_scheme_gate: assert property (
      @(posedge pclk) disable iff (!presetn)
      (wr_en && hit_ctl && !sel_uses_tbl) |=> !load_table_request)
      else $error("load with table unused");

   // Arbiter's done walks the sequencer back to idle
   chk_load_finish: assert property (
      @(posedge pclk) disable iff (!presetn)
      (st_q == vc_ctl_pkg::LD_BUSY && load_done) |=> s_finish)
      else $error("load did not finish");

   ////////////////////////////////////////////////////////////////////////
   // Pending flag; a table write in the finishing cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_q <= 1'b0;
      end else if (table_write && UPSTREAM) begin
         pend_q <= 1'b1;
      end else if (ld_fin) begin
         pend_q <= 1'b0;
      end
   end

   // A table entry write raises pending next cycle
   chk_pend_set: assert property (
      @(posedge pclk) disable iff (!presetn)
      (table_write && UPSTREAM) |=> pend_q)
      else $error("pending not set");

   // Finishing load clears pending unless a write collides
   chk_pend_clear: assert property (
      @(posedge pclk) disable iff (!presetn)
      (ld_fin && !table_write) |=> !pend_q)
      else $error("pending not cleared");

   // Pending holds until the load finishes
   chk_pend_hold: assert property (
      @(posedge pclk) disable iff (!presetn)
      (pend_q && !ld_fin) |=> pend_q)
      else $error("pending dropped early");

   ////////////////////////////////////////////////////////////////////////
   // Negotiation pending: set entering FC_INIT2, clear on exit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init2_q <= 1'b0;
         neg_q   <= 1'b0;
      end else begin
         init2_q <= fc_init2;
         if (fc_init2) neg_q <= 1'b1;
         else if (neg_fall) neg_q <= 1'b0;
      end
   end

   // Pending shows while flow control init runs
   chk_neg_set: assert property (
      @(posedge pclk) disable iff (!presetn)
      fc_init2 |=> neg_q)
      else $error("neg not set");

   // Leaving init2 clears pending one cycle later
   chk_neg_clear: assert property (
      @(posedge pclk) disable iff (!presetn)
      $fell(fc_init2) |=> !neg_q)
      else $error("neg not cleared");

   ////////////////////////////////////////////////////////////////////////
   // Interrupt registers; a new event beats a clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ist_q <= '0;
         ien_q <= '0;
         irq_q <= 1'b0;
      end else begin
         ist_q <= ev | (ist_q & ~((wr_en && hit_icl)
                  ? pwdata[`EV_COUNT-1:0] : '0));
         if (wr_en && hit_ien) ien_q <= pwdata[`EV_COUNT-1:0];
         irq_q <= |(ist_q & ien_q);
      end
   end

   // Each event lands in its sticky bit, even against a clear
   for (genvar i = 0; i < `EV_COUNT; i++) begin : g_ev_chk
      chk_ev_sticky: assert property (
         @(posedge pclk) disable iff (!presetn)
         ev[i] |=> ist_q[i])
         else $error("event not latched");
   end

   // Level interrupt follows enabled status by one cycle
   chk_irq_level: assert property (
      @(posedge pclk) disable iff (!presetn)
      (|(ist_q & ien_q)) |=> irq)
      else $error("irq missing");

   ////////////////////////////////////////////////////////////////////////
   // Read mux; unlisted bits stay zero
   wire logic [31:0] ctl_rd = {1'b1,
                               4'h0, `CHID_VALUE,
                               4'h0, sel_q, 1'b0,
                               8'h00, map_q};
   // Pending is only meaningful for a table scheme; we show it raw
   wire logic [31:0] sts_rd = {14'h0000,
                               neg_q & link_active,
                               pend_q & UPSTREAM,
                               16'h0000};
   wire logic [31:0] rd_mux = hit_ctl ? ctl_rd
                            : hit_sts ? sts_rd
                            : hit_ist ? {29'h0, ist_q}
                            : hit_ien ? {29'h0, ien_q}
                            : 32'h00000000;

   // APB slave: no wait states, data captured in setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 32'h00000000;
         ready_q <= 1'b0;
         err_q   <= 1'b0;
      end else begin
         ready_q <= st_en;
         err_q   <= st_en & ~mapped;
         if (rd_en) rdata_q <= rd_mux;
      end
   end

   // Setup phase of a transfer
   sequence s_setup;
      psel && !penable;
   endsequence

   // Ready stands for exactly the access cycle
   sequence s_answer;
      pready ##1 !pready;
   endsequence

   // Every setup is answered in the following cycle
   chk_apb_answer: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_setup |=> s_answer)
      else $error("apb answer wrong");

   // Unmapped addresses answer with an error
   chk_err_unmapped: assert property (
      @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !mapped) |=> (pready && pslverr))
      else $error("unmapped address not refused");

   // Fixed control fields read as constants
   chk_ctl_fixed: assert property (
      @(posedge pclk) disable iff (!presetn)
      (rd_en && hit_ctl) |=> (prdata[`ENABLE_BIT] &&
      prdata[`CHID_MSB:`CHID_LSB] == `CHID_VALUE))
      else $error("fixed fields wrong");

   // Reserved control bits and the load bit read zero
   chk_ctl_rsv: assert property (
      @(posedge pclk) disable iff (!presetn)
      (rd_en && hit_ctl) |=> (prdata & `CTL_RSV_MASK) == 32'h00000000)
      else $error("control reserved bits set");

   // Reserved status bits read zero
   chk_sts_rsv: assert property (
      @(posedge pclk) disable iff (!presetn)
      (rd_en && hit_sts) |=> (prdata & `STS_RSV_MASK) == 32'h00000000)
      else $error("status reserved bits set");

   // Downstream ports never show a pending table
   chk_down_pend: assert property (
      @(posedge pclk) disable iff (!presetn)
      (rd_en && hit_sts && !UPSTREAM) |=> !prdata[`PEND_BIT])
      else $error("downstream pending shown");

   // Negotiation bit hidden while the link is down
   chk_neg_read: assert property (
      @(posedge pclk) disable iff (!presetn)
      (rd_en && hit_sts && !link_active) |=> !prdata[`NEG_BIT])
      else $error("neg shown with link down");

   assign prdata  = rdata_q;
   assign pready  = ready_q;
   assign pslverr = err_q;
   assign irq     = irq_q;
   assign class_to_channel_map      = map_q;
   assign arbitration_scheme_select = sel_q;
   // Arbiter applies the table; invalid port phases are its to skip
   assign load_table_request        = req_q;

endmodule : vc_resource_control_status

// ### testbench/testbench.sv
`include "vc_ctl_defs.svh"

module testbench;
   timeunit 1ns;
   timeprecision 1ps;

   logic        pclk;         // Core clock, 8 ns
   logic        presetn;      // Reset, active low
   logic        psel_up;      // Select, upstream port
   logic        psel_dn;      // Select, downstream port
   logic        penable;      // Access phase, shared
   logic        pwrite;       // Direction, shared
   logic [11:0] paddr;        // Address, shared
   logic [31:0] pwdata;       // Write data, shared
   logic [31:0] prdata_up;    // Read data, upstream
   logic [31:0] prdata_dn;    // Read data, downstream
   logic        pready_up;    // Ready, upstream
   logic        pready_dn;    // Ready, downstream
   logic        err_up;       // Error, upstream
   logic        err_dn;       // Error, downstream
   logic        table_write;  // Table entry written
   logic        load_done;    // Arbiter latched table
   logic        link_active;  // Link active level
   logic        fc_init2;     // Link in init2
   logic [7:0]  map_up;       // Class map output
   logic [2:0]  sel_up;       // Scheme output
   logic        req_up;       // Load pulse, upstream
   logic        req_dn;       // Load pulse, downstream
   logic        irq;          // Interrupt, upstream
   logic [31:0] rd;           // Last read word
   logic        err;          // Last error flag
   int          mismatches;   // Failed compares
   int          checked;      // Compares made
   int          nreq_up;      // Load pulses seen up
   int          nreq_dn;      // Load pulses seen down
   int          cycles;       // Timeout counter

   vc_resource_control_status #(.UPSTREAM(1'b1)) DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel_up), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_up),
      .pready(pready_up), .pslverr(err_up), .table_write(table_write),
      .load_done(load_done), .link_active(link_active),
      .fc_init2(fc_init2), .class_to_channel_map(map_up),
      .arbitration_scheme_select(sel_up), .load_table_request(req_up),
      .irq(irq));

   // Downstream flavour shares the bus; only its select differs
   vc_resource_control_status #(.UPSTREAM(1'b0)) DUT_DN (
      .pclk(pclk), .presetn(presetn), .psel(psel_dn), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata_dn),
      .pready(pready_dn), .pslverr(err_dn), .table_write(table_write),
      .load_done(load_done), .link_active(link_active),
      .fc_init2(fc_init2), .class_to_channel_map(),
      .arbitration_scheme_select(), .load_table_request(req_dn),
      .irq());

   ////////////////////////////////////////////////////////////////////////
   // Clock, pulse counters and hang guard
   always #4 pclk = ~pclk;

   always @(posedge pclk) begin
      nreq_up += (req_up === 1'b1);
      nreq_dn += (req_dn === 1'b1);
      cycles++;
      if (cycles == 4000) begin  // Far above the run's length
         mismatches++;
         end_of_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic cmp(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : cmp

   // One APB transfer; holds everything until ready is sampled high
   task automatic apb(input bit dn, input logic wr, input logic [11:0] a,
                      input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel_up <= !dn;
      psel_dn <= dn;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while ((dn ? pready_dn : pready_up) !== 1'b1 && n < 50);
      if (n >= 50) mismatches++;  // Slave never answered
      rd = dn ? prdata_dn : prdata_up;
      err = dn ? err_dn : err_up;
      psel_up <= 1'b0;
      psel_dn <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic pulse_tw();
      @(posedge pclk) table_write <= 1'b1;
      @(posedge pclk) table_write <= 1'b0;
   endtask : pulse_tw

   task automatic end_of_test();
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_of_test

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      {pclk, presetn, psel_up, psel_dn, penable, pwrite} = '0;
      {paddr, pwdata, table_write, load_done, link_active, fc_init2} = '0;
      {mismatches, checked, nreq_up, nreq_dn, cycles} = '0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values of both registers and outputs
      apb(0, 0, `OFS_CONTROL, 0);
      cmp(rd, 32'h800000FF);
      apb(0, 0, `OFS_STATUS, 0);
      cmp(rd, 32'h00000000);
      cmp({map_up, sel_up}, {8'hFF, 3'h0});
      $display("test reset done");
      // Ones in reserved and fixed bits, scheme 1, map zero, load bit clear; fixed fields must not move
      apb(0, 1, `OFS_CONTROL, 32'hFFF2FF00);
      apb(0, 0, `OFS_CONTROL, 0);
      cmp(rd, 32'h80020001);
      cmp({map_up, sel_up}, {8'h01, 3'h1});
      cmp(nreq_up, 0);
      $display("test write fields done");
      // Table write sets pending, which holds until the load finishes
      pulse_tw();
      apb(0, 0, `OFS_STATUS, 0);
      cmp(rd, 32'h00010000);
      apb(0, 1, `OFS_CONTROL, 32'h000300FF);
      repeat (2) @(posedge pclk);
      cmp(nreq_up, 1);
      apb(0, 0, `OFS_STATUS, 0);
      cmp(rd, 32'h00010000);
      @(posedge pclk) load_done <= 1'b1;
      @(posedge pclk) load_done <= 1'b0;
      repeat (3) @(posedge pclk);
      apb(0, 0, `OFS_STATUS, 0);
      cmp(rd, 32'h00000000);
      // Fixed round robin selected: a load request does nothing
      apb(0, 1, `OFS_CONTROL, 32'h000000FF);
      apb(0, 1, `OFS_CONTROL, 32'h000100FF);
      repeat (2) @(posedge pclk);
      cmp(nreq_up, 1);
      $display("test table load done");
      // Negotiation pending follows init2 while the link is active
      link_active <= 1'b1;
      fc_init2    <= 1'b1;
      apb(0, 0, `OFS_STATUS, 0);
      cmp(rd, 32'h00020000);
      fc_init2 <= 1'b0;
      apb(0, 0, `OFS_STATUS, 0);
      cmp(rd, 32'h00000000);
      $display("test negotiation done");
      // Downstream: no load, pending always zero
      apb(1, 1, `OFS_CONTROL, 32'h000100FF);
      repeat (2) @(posedge pclk);
      cmp(nreq_dn, 0);
      apb(1, 0, `OFS_STATUS, 0);
      cmp(rd, 32'h00000000);
      $display("test downstream done");
      // Events: load done, table write, negotiation done
      apb(0, 0, `OFS_IRQ_STATUS, 0);
      cmp(rd, 32'h00000007);
      cmp(irq, 1'b0);
      apb(0, 1, `OFS_IRQ_ENABLE, 32'h00000007);
      repeat (2) @(posedge pclk);
      cmp(irq, 1'b1);
      apb(0, 1, `OFS_IRQ_CLEAR, 32'h00000007);
      repeat (2) @(posedge pclk);
      apb(0, 0, `OFS_IRQ_STATUS, 0);
      cmp(rd, 32'h00000000);
      cmp(irq, 1'b0);
      apb(0, 1, `OFS_IRQ_ENABLE, 32'h00000001);
      pulse_tw();
      repeat (2) @(posedge pclk);
      cmp(irq, 1'b0);  // Masked event stays quiet
      apb(0, 1, `OFS_IRQ_ENABLE, 32'h00000002);
      repeat (2) @(posedge pclk);
      cmp(irq, 1'b1);
      $display("test interrupt done");
      // Unmapped address reads zero; cmp's 32-bit inputs drop the err bit
      apb(0, 0, 12'h400, 0);
      cmp({err, rd}, {1'b1, 32'h00000000});
      $display("test unmapped done");
      end_of_test();
   end
endmodule : testbench
